// ### design/see_bus_if.sv
// two-wire bus between master and eeprom slave, open-drain data resolved here
interface see_bus_if;
  logic scl;
  logic sda;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaDevOut;
  logic sdaDevOe;

  // pull-up gives the high level, either party may only pull low
  assign sda = !((sdaMstOe && !sdaMstOut) || (sdaDevOe && !sdaDevOut));

  modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport mst (output scl, input sda, output sdaMstOut, output sdaMstOe);
endinterface : see_bus_if

// ### design/see_device.sv
// eeprom slave end: line filter, bus conditions, page buffer, timed commit
// Functional notes
// - storage is linear array of bytes
// - page buffer gathers up to eight bytes
// - self-timed commit finishing within ten ms
// - data line only pulled low or released
// - data changes only while clock low
// - data change with clock high is condition
// - master makes clock, start and stop
// - master chooses direction, slave follows it
// - master starts only on idle bus
// - both lines high means idle, released
// - output waits 300 ns after falling clock
// - pulses up to 50 ns are ignored
// - data falling with clock high starts
// - data rising with clock high stops
// - no acknowledge while write cycle runs
// - page write wraps low three address bits
module see_device #(
  parameter int WRITE_CYC = see_pkg::TWC_CYC  // self-timed write length in cycles
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rstn,    // async reset
  see_bus_if.dev    bus,     // two-wire bus
  output logic      busy     // internal write cycle running
);
  import see_pkg::*;
  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WRITE_CYC - 1);

  logic [1:0]      sync1;
  logic [1:0]      sync2;
  logic [1:0]      sync3;
  logic [1:0]      filt;
  logic [1:0]      next_filt;
  logic [1:0]      filtPrev;
  logic [3:0]      fCnt [2];
  logic [3:0]      next_fCnt [2];
  logic            sclF;
  logic            sdaF;
  logic            sclRise;
  logic            sclFall;
  logic            startEv;
  logic            stopEv;
  see_dst_t        state;
  see_dst_t        next_state;
  logic [3:0]      bitCnt;
  logic [3:0]      next_bitCnt;
  logic [7:0]      shReg;
  logic [7:0]      next_shReg;
  logic [7:0]      ptr;
  logic [7:0]      next_ptr;
  logic            rw;
  logic            next_rw;
  logic            pend;
  logic            next_pend;
  logic            pull;
  logic            next_pull;
  logic [6:0]      holdCnt;
  logic [6:0]      next_holdCnt;
  logic [7:0]      pageBuf [PAGE_BYTES];
  logic [7:0]      next_pageBuf [PAGE_BYTES];
  logic [7:0]      pageVld;
  logic [7:0]      next_pageVld;
  logic            next_busy;
  logic [WC_W-1:0] wcCnt;
  logic [WC_W-1:0] next_wcCnt;
  logic            commit;
  logic [7:0]      mem [MEM_BYTES];

  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe  = pull;

  // a change must stand FILT_CYC cycles after the second and third stages agree
  always_comb
  begin
    next_filt = filt;
    for (int i = 0; i < 2; i++)
    begin
      next_fCnt[i] = '0;
      if (sync2[i] == sync3[i] && sync3[i] != filt[i])
      begin
        if (fCnt[i] == FILT_LAST)
          next_filt[i] = sync3[i];
        else
          next_fCnt[i] = fCnt[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1    <= LINES_RST;
      sync2    <= LINES_RST;
      sync3    <= LINES_RST;
      filt     <= LINES_RST;
      filtPrev <= LINES_RST;
      fCnt[0]  <= '0;
      fCnt[1]  <= '0;
    end
    else
    begin
      sync1    <= {bus.scl, bus.sda};
      sync2    <= sync1;
      sync3    <= sync2;
      filt     <= next_filt;
      filtPrev <= filt;
      fCnt     <= next_fCnt;
    end
  end

  assign sclF    = filt[1];
  assign sdaF    = filt[0];
  assign sclRise = sclF && !filtPrev[1];
  assign sclFall = !sclF && filtPrev[1];
  // data edges under a high clock are conditions
  assign startEv = sclF && filtPrev[1] && filtPrev[0] && !sdaF;
  assign stopEv  = sclF && filtPrev[1] && !filtPrev[0] && sdaF;

  always_comb
  begin
    next_state   = state;
    next_bitCnt  = bitCnt;
    next_shReg   = shReg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_pend    = pend;
    next_pull    = pull;
    next_holdCnt = holdCnt;
    next_pageBuf = pageBuf;
    next_pageVld = pageVld;
    next_busy    = busy;
    next_wcCnt   = wcCnt;
    commit       = 1'b0;
    // commit at the end of the timed cycle
    if (busy)
    begin
      if (wcCnt == '0)
      begin
        next_busy    = 1'b0;
        commit       = 1'b1;
        next_pageVld = '0;
      end
      else
        next_wcCnt = wcCnt - WC_W'(1);
    end
    // drive change lands HOLD_CYC after the falling clock
    if (holdCnt != '0)
    begin
      next_holdCnt = holdCnt - 7'h1;
      if (holdCnt == 7'h1)
        next_pull = pend;
    end
    if (startEv || stopEv)
    begin
      // conditions restart or end the transfer
      next_state   = startEv ? D_CTRL : D_IDLE;
      next_bitCnt  = '0;
      next_pend    = 1'b0;
      next_pull    = 1'b0;
      next_holdCnt = '0;
      // stop after written data launches the cycle
      if (stopEv && state == D_WDATA && pageVld != '0)
      begin
        next_busy  = 1'b1;
        next_wcCnt = WC_LAST;
      end
      else if (!busy)
        next_pageVld = '0;
    end
    else if (state != D_IDLE && sclRise)
    begin
      // data taken on the rising clock
      if (bitCnt < 4'(ACK_BIT))
      begin
        next_shReg  = (state == D_RDATA) ? shReg : {shReg[6:0], sdaF};
        next_bitCnt = bitCnt + 4'h1;
      end
      else
      begin
        next_bitCnt = 4'(ACK_BIT + 1);
        // master ends a read by withholding its acknowledge
        if (state == D_RDATA && sdaF)
          next_state = D_IDLE;
      end
    end
    else if (state != D_IDLE && sclFall)
    begin
      next_holdCnt = HOLD_LD;
      if (bitCnt == 4'(ACK_BIT))
      begin
        next_pend = 1'b1;
        unique case (state)
          D_IDLE:
            next_pend = 1'b0;
          D_CTRL:
            // silent while busy or when the code does not match
            if (busy || shReg[7:4] != DEV_CODE)
            begin
              next_pend  = 1'b0;
              next_state = D_IDLE;
            end
            else
              next_rw = shReg[0];
          D_ADDR:
          begin
            next_ptr     = shReg;
            next_pageVld = '0;
          end
          D_WDATA:
          begin
            next_pageBuf[ptr[2:0]] = shReg;
            next_pageVld[ptr[2:0]] = 1'b1;
            // only the low three bits advance
            next_ptr = {ptr[7:3], ptr[2:0] + 3'h1};
          end
          D_RDATA:
            next_pend = 1'b0;
        endcase
      end
      else if (bitCnt == 4'(ACK_BIT + 1))
      begin
        next_bitCnt = '0;
        next_pend   = 1'b0;
        // direction taken from the control byte
        if (state == D_CTRL)
          next_state = rw ? D_RDATA : D_ADDR;
        else if (state == D_ADDR)
          next_state = D_WDATA;
        if (state == D_RDATA || (state == D_CTRL && rw))
        begin
          next_shReg = mem[ptr];
          next_ptr   = ptr + 8'h1;
          next_pend  = !mem[ptr][7];
        end
      end
      else if (state == D_RDATA && bitCnt != '0)
        next_pend = !shReg[3'(7 - bitCnt)];
      else
        next_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state   <= D_IDLE;
      bitCnt  <= '0;
      shReg   <= '0;
      ptr     <= '0;
      rw      <= 1'b0;
      pend    <= 1'b0;
      pull    <= 1'b0;
      holdCnt <= '0;
      pageVld <= '0;
      busy    <= 1'b0;
      wcCnt   <= '0;
      for (int i = 0; i < PAGE_BYTES; i++)
        pageBuf[i] <= '0;
    end
    else
    begin
      state   <= next_state;
      bitCnt  <= next_bitCnt;
      shReg   <= next_shReg;
      ptr     <= next_ptr;
      rw      <= next_rw;
      pend    <= next_pend;
      pull    <= next_pull;
      holdCnt <= next_holdCnt;
      pageVld <= next_pageVld;
      busy    <= next_busy;
      wcCnt   <= next_wcCnt;
      pageBuf <= next_pageBuf;
    end
  end

  // whole page lands at once; untouched slots keep their old bytes
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
        mem[i] <= ERASED;
    end
    else if (commit)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        if (pageVld[i])
          mem[{ptr[7:3], 3'(i)}] <= pageBuf[i];
    end
  end
endmodule : see_device

// ### design/see_fifo.sv
// write-data fifo in front of the bus master
module see_fifo #(
  parameter int WIDTH = see_pkg::DATA_W,
  parameter int DEPTH = see_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rstn,     // async reset
  input  wire logic             inValid,  // producer offers a word
  output logic                  inReady,  // room for a word
  input  wire logic [WIDTH-1:0] inData,   // word in
  output logic                  outValid, // word available
  input  wire logic             outReady, // consumer takes it
  output logic      [WIDTH-1:0] outData   // oldest word
);
  import see_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;

  // extra pointer bit tells full from empty
  assign inReady  = !(wrPtr[AW] != rdPtr[AW] && wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign outValid = wrPtr != rdPtr;
  assign outData  = store[rdPtr[AW-1:0]];

  always_comb
  begin
    next_wrPtr = (inValid && inReady) ? wrPtr + (AW+1)'(1) : wrPtr;
    next_rdPtr = (outValid && outReady) ? rdPtr + (AW+1)'(1) : rdPtr;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (inValid && inReady)
      store[wrPtr[AW-1:0]] <= inData;
  end
endmodule : see_fifo

// ### design/see_master.sv
// bus master end: clock divider, start/stop generation, byte engine
module see_master (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rstn,     // async reset
  see_bus_if.mst          bus,      // two-wire bus
  input  wire logic       cmdValid, // command offered
  output logic            cmdReady, // master idle, takes command
  input  wire logic       cmdRead,  // 1 read, 0 write
  input  wire logic [7:0] cmdAddr,  // word address
  input  wire logic [3:0] cmdLen,   // byte count minus one
  input  wire logic       wrValid,  // write byte offered
  output logic            wrReady,  // fifo has room
  input  wire logic [7:0] wrData,   // write byte
  output logic            rdValid,  // read byte pulse
  output logic      [7:0] rdData,   // read byte
  output logic            done,     // transfer finished pulse
  output logic            nack      // last transfer refused
);
  import see_pkg::*;

  see_mst_t   mst;
  see_mst_t   next_mst;
  see_step_t  step;
  see_step_t  next_step;
  logic [1:0]  q;
  logic [1:0]  next_q;
  logic [10:0] qCnt;
  logic [10:0] next_qCnt;
  logic [3:0]  bitNo;
  logic [3:0]  next_bitNo;
  logic [7:0]  txByte;
  logic [7:0]  next_txByte;
  logic [3:0]  left;
  logic [3:0]  next_left;
  logic        isRead;
  logic        next_isRead;
  logic [7:0]  addr;
  logic [7:0]  next_addr;
  logic        sclO;
  logic        next_sclO;
  logic        sdaLow;
  logic        next_sdaLow;
  logic [7:0]  next_rdData;
  logic        next_rdValid;
  logic        next_done;
  logic        next_nack;
  logic        s1;
  logic        s2;
  logic        s3;
  logic        sdaS;
  logic        next_sdaS;
  logic        tick;
  logic        sending;
  logic        fVal;
  logic        fPop;
  logic [7:0]  fData;

  see_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrData),
    .outValid (fVal),
    .outReady (fPop),
    .outData  (fData)
  );

  assign bus.scl       = sclO;
  assign bus.sdaMstOut = 1'b0;
  assign bus.sdaMstOe  = sdaLow;
  assign cmdReady      = (mst == M_IDLE);
  assign tick          = (qCnt == '0);
  assign sending       = (step != P_RDATA);

  always_comb
  begin
    next_mst     = mst;
    next_step    = step;
    next_q       = q;
    next_qCnt    = tick ? QUART_LD : qCnt - 11'h1;
    next_bitNo   = bitNo;
    next_txByte  = txByte;
    next_left    = left;
    next_isRead  = isRead;
    next_addr    = addr;
    next_sclO    = sclO;
    next_sdaLow  = sdaLow;
    next_rdData  = rdData;
    next_rdValid = 1'b0;
    next_done    = 1'b0;
    next_nack    = nack;
    next_sdaS    = (s2 == s3) ? s3 : sdaS;
    fPop         = 1'b0;
    unique case (mst)
      M_IDLE:
      begin
        next_qCnt   = QUART_LD;
        next_sclO   = 1'b1;
        next_sdaLow = 1'b0;
        if (cmdValid)
        begin
          next_mst    = M_START;
          next_q      = 2'h2;
          next_step   = P_CTRLW;
          next_isRead = cmdRead;
          next_addr   = cmdAddr;
          next_left   = cmdLen;
          next_nack   = 1'b0;
        end
      end
      M_START:
        if (tick)
        begin
          next_q = q + 2'h1;
          unique case (q)
            2'h0: next_sclO = 1'b0;
            2'h1: next_sdaLow = 1'b0;
            2'h2: next_sclO = 1'b1;
            2'h3:
            begin
              // data falls with the clock high
              next_sdaLow = 1'b1;
              next_mst    = M_BYTE;
              next_bitNo  = '0;
              next_txByte = {DEV_CODE, 3'h0, step == P_CTRLR};
            end
          endcase
        end
      M_BYTE:
        if (tick)
        begin
          next_q = q + 2'h1;
          unique case (q)
            2'h0: next_sclO = 1'b0;
            // data changes only with the clock low
            2'h1:
              if (bitNo < 4'(ACK_BIT))
                next_sdaLow = sending && !txByte[7];
              else
                next_sdaLow = !sending && left != '0;
            2'h2: next_sclO = 1'b1;
            2'h3:
            begin
              next_bitNo = bitNo + 4'h1;
              if (bitNo < 4'(ACK_BIT))
              begin
                next_txByte = {txByte[6:0], sending ? 1'b0 : sdaS};
                if (!sending && bitNo == 4'h7)
                begin
                  next_rdData  = {txByte[6:0], sdaS};
                  next_rdValid = 1'b1;
                end
              end
              else if (sending && sdaS)
              begin
                next_nack = 1'b1;
                next_mst  = M_STOP;
              end
              else
              begin
                next_bitNo = '0;
                unique case (step)
                  P_CTRLW:
                  begin
                    next_step   = P_ADDR;
                    next_txByte = addr;
                  end
                  P_ADDR:
                  begin
                    next_step = isRead ? P_CTRLR : P_WDATA;
                    next_mst  = isRead ? M_START : M_LOAD;
                  end
                  P_WDATA:
                  begin
                    next_mst  = (left == '0) ? M_STOP : M_LOAD;
                    next_left = left - 4'h1;
                  end
                  P_CTRLR:
                    next_step = P_RDATA;
                  P_RDATA:
                  begin
                    if (left == '0)
                      next_mst = M_STOP;
                    next_left = left - 4'h1;
                  end
                endcase
              end
            end
          endcase
        end
      M_LOAD:
      begin
        // clock held low while the fifo is empty stalls the whole transfer
        next_sclO = 1'b0;
        next_qCnt = QUART_LD;
        if (fVal)
        begin
          fPop        = 1'b1;
          next_txByte = fData;
          next_mst    = M_BYTE;
          next_bitNo  = '0;
          next_q      = 2'h0;
        end
      end
      M_STOP:
        if (tick)
        begin
          next_q = q + 2'h1;
          unique case (q)
            2'h0: next_sclO = 1'b0;
            2'h1: next_sdaLow = 1'b1;
            2'h2: next_sclO = 1'b1;
            2'h3:
            begin
              // data rises with the clock high
              next_sdaLow = 1'b0;
              next_mst    = M_IDLE;
              next_done   = 1'b1;
            end
          endcase
        end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mst     <= M_IDLE;
      step    <= P_CTRLW;
      q       <= '0;
      qCnt    <= QUART_LD;
      bitNo   <= '0;
      txByte  <= '0;
      left    <= '0;
      isRead  <= 1'b0;
      addr    <= '0;
      sclO    <= 1'b1;
      sdaLow  <= 1'b0;
      rdData  <= '0;
      rdValid <= 1'b0;
      done    <= 1'b0;
      nack    <= 1'b0;
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      sdaS    <= 1'b1;
    end
    else
    begin
      mst     <= next_mst;
      step    <= next_step;
      q       <= next_q;
      qCnt    <= next_qCnt;
      bitNo   <= next_bitNo;
      txByte  <= next_txByte;
      left    <= next_left;
      isRead  <= next_isRead;
      addr    <= next_addr;
      sclO    <= next_sclO;
      sdaLow  <= next_sdaLow;
      rdData  <= next_rdData;
      rdValid <= next_rdValid;
      done    <= next_done;
      nack    <= next_nack;
      s1      <= bus.sda;
      s2      <= s1;
      s3      <= s2;
      sdaS    <= next_sdaS;
    end
  end
endmodule : see_master

// ### design/see_pkg.sv
// shared constants and types of the two-wire eeprom slave and its bus master
package see_pkg;
  localparam int CLK_NS     = 4;
  localparam int SPIKE_NS   = 50;
  localparam int FILT_CYC   = SPIKE_NS / CLK_NS + 1;
  localparam int HOLD_NS    = 300;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWC_MS     = 10;
  localparam int TWC_CYC    = TWC_MS * 1000000 / CLK_NS;
  // about 380 kHz: a 660 ns quarter keeps each clock low half above the fast-mode low minimum
  localparam int SCL_NS     = 2640;
  localparam int QUART_CYC  = SCL_NS / 4 / CLK_NS;
  localparam int MEM_BYTES  = 256;
  localparam int PAGE_BYTES = 8;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ACK_BIT    = 8;
  localparam int WC_W       = 22;
  localparam logic [3:0]  FILT_LAST = 4'(FILT_CYC - 1);
  localparam logic [6:0]  HOLD_LD   = 7'(HOLD_CYC);
  localparam logic [10:0] QUART_LD  = 11'(QUART_CYC - 1);
  localparam logic [7:0]  ERASED    = 8'hff;
  localparam logic [1:0]  LINES_RST = 2'h3;
  // device code value is arbitrary
  localparam logic [3:0]  DEV_CODE  = 4'h5;

  typedef enum logic [4:0] {
    D_IDLE  = 5'h01,
    D_CTRL  = 5'h02,
    D_ADDR  = 5'h04,
    D_WDATA = 5'h08,
    D_RDATA = 5'h10
  } see_dst_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BYTE  = 5'h04,
    M_LOAD  = 5'h08,
    M_STOP  = 5'h10
  } see_mst_t;

  typedef enum logic [4:0] {
    P_CTRLW = 5'h01,
    P_ADDR  = 5'h02,
    P_WDATA = 5'h04,
    P_CTRLR = 5'h08,
    P_RDATA = 5'h10
  } see_step_t;
endpackage : see_pkg

// ### tb/see_bus_sva.sv
// timing checker watching the two-wire link between master and slave
module see_bus_sva (
  input wire logic clk_sys,   // clock
  input wire logic rstn,      // reset
  input wire logic scl,       // bus clock
  input wire logic sda,       // data line
  input wire logic sdaMstOut, // master value
  input wire logic sdaMstOe,  // master pulls
  input wire logic sdaDevOut, // device value
  input wire logic sdaDevOe   // device pulls
);
  import see_pkg::*;
  // 600 ns: clock high, start hold and stop setup minimum
  localparam int HI_MIN = 150;
  localparam int Q_MAX  = 2 * QUART_CYC;
  localparam int SU_MIN = 63;
  localparam int SU_MAX = 2 * QUART_CYC;
  logic [31:0] hiCnt;
  logic [31:0] loCnt;
  logic [31:0] stCnt;
  logic [31:0] suCnt;
  logic [31:0] next_hiCnt;
  logic [31:0] next_loCnt;
  logic [31:0] next_stCnt;
  logic [31:0] next_suCnt;
  logic        sdaPrev;
  logic        oePrev;
  logic        inStart;
  logic        suPend;
  logic        next_inStart;
  logic        next_suPend;
  // phase lengths; a run is far too short to wrap them
  always_comb
  begin
    next_hiCnt   = scl ? hiCnt + 32'h1 : 32'h0;
    next_loCnt   = scl ? 32'h0 : loCnt + 32'h1;
    // a start stays open until the clock first falls
    next_inStart = (scl && sdaPrev && !sda) || (inStart && scl);
    next_stCnt   = (next_inStart && inStart) ? stCnt + 32'h1 : 32'h0;
    // a device pull stays open until the clock next rises
    next_suPend  = (sdaDevOe && !oePrev) || (suPend && !scl);
    next_suCnt   = (next_suPend && suPend) ? suCnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hiCnt   <= 32'h0;
      loCnt   <= 32'h0;
      stCnt   <= 32'h0;
      suCnt   <= 32'h0;
      sdaPrev <= 1'b1;
      oePrev  <= 1'b0;
      inStart <= 1'b0;
      suPend  <= 1'b0;
    end
    else
    begin
      hiCnt   <= next_hiCnt;
      loCnt   <= next_loCnt;
      stCnt   <= next_stCnt;
      suCnt   <= next_suCnt;
      sdaPrev <= sda;
      oePrev  <= sdaDevOe;
      inStart <= next_inStart;
      suPend  <= next_suPend;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_dev_pull_only: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("device drives high");
  a_mst_pull_only: assert property (sdaMstOe |-> !sdaMstOut)
    else $error("master drives high");
  a_dev_high_stable: assert property (
    scl && $past(scl) |-> $stable(sdaDevOe))
    else $error("device data moved while clock high");
  a_dev_hold_off: assert property (
    $changed(sdaDevOe) && !scl |-> loCnt >= 32'(HOLD_CYC))
    else $error("device data changed too soon");
  a_scl_high_time: assert property ($fell(scl) |-> hiCnt >= 32'(HI_MIN))
    else $error("clock high too short");
  a_start_hold: assert property (
    inStart |-> !sda && (scl || (stCnt >= 32'(HI_MIN) && stCnt <= 32'(Q_MAX))))
    else $error("start not held");
  a_stop_idle: assert property (
    $rose(sda) && scl |-> hiCnt >= 32'(HI_MIN) ##1 (scl && sda) [*8])
    else $error("bus not idle after stop");
  a_dev_setup: assert property (
    suPend |-> suCnt <= 32'(SU_MAX) && (!scl || suCnt >= 32'(SU_MIN)))
    else $error("device drive not ahead of clock");
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_dev_drive: cover property ($rose(sdaDevOe));
endmodule : see_bus_sva

// ### tb/serial_eeprom_two_wire_slave_test.sv
// self-checking bench: master and eeprom slave joined over the link
module serial_eeprom_two_wire_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import see_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  len;
    logic [63:0] d;
  } see_row_t;
  // long enough that a command right after a write still meets it busy
  localparam int WCYC = 8000;
  logic       clk_sys  = 1'b0;
  logic       rstn     = 1'b0;
  logic       cmdValid = 1'b0;
  logic       cmdRead  = 1'b0;
  logic [7:0] cmdAddr  = 8'h00;
  logic [3:0] cmdLen   = 4'h0;
  logic       wrValid  = 1'b0;
  logic [7:0] wrData   = 8'h00;
  logic       cmdReady, wrReady, rdValid, done, nack, busy, ok;
  logic [7:0] rdData;
  logic [7:0] got [8];
  see_row_t   rows [2];
  int         errors   = 0;
  int         n_checks = 0;
  int         cycles   = 0;
  int         i, j, k, n, nGot;
  see_bus_if bus ();
  see_master u_see_master (.clk_sys(clk_sys), .rstn(rstn), .bus(bus.mst),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack));
  see_device #(.WRITE_CYC(WCYC)) u_see_device (.clk_sys(clk_sys), .rstn(rstn),
    .bus(bus.dev), .busy(busy));
  see_bus_sva u_see_bus_sva (.clk_sys(clk_sys), .rstn(rstn), .scl(bus.scl),
    .sda(bus.sda), .sdaMstOut(bus.sdaMstOut), .sdaMstOe(bus.sdaMstOe),
    .sdaDevOut(bus.sdaDevOut), .sdaDevOe(bus.sdaDevOe));
  always #2 clk_sys = ~clk_sys;
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // the whole sequence needs about 130000 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 180000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // offers one byte only when the fifo shows room, else reports refusal
  task automatic push(input logic [7:0] b, output logic taken);
    @(negedge clk_sys);
    taken = wrReady;
    if (taken === 1'b1)
    begin
      wrValid = 1'b1;
      wrData = b;
      @(negedge clk_sys);
      wrValid = 1'b0;
    end
  endtask : push
  task automatic run(input logic rd, input logic [7:0] a, input logic [3:0] len);
    @(negedge clk_sys);
    while (cmdReady !== 1'b1)
      @(negedge clk_sys);
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdAddr = a;
    cmdLen = len;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    nGot = 0;
    k = 0;
    while (done !== 1'b1 && k < 800000)
    begin
      if (rdValid === 1'b1 && nGot < 8)
      begin
        got[nGot] = rdData;
        nGot++;
      end
      @(negedge clk_sys);
      k++;
    end
    check({7'h0, done}, 8'h01);
    // the slave's filters see the stop some cycles after done
    repeat (32) @(negedge clk_sys);
  endtask : run
  task automatic waitIdle();
    k = 0;
    while (busy !== 1'b0 && k < WCYC + 10)
    begin
      @(negedge clk_sys);
      k++;
    end
    check({7'h0, busy}, 8'h00);
  endtask : waitIdle
  initial
  begin
    // page write at 07 wraps to 00; the read sees erased bytes between
    rows[0] = '{1'b0, 8'h07, 4'h1, 64'h3ca5};
    rows[1] = '{1'b1, 8'h00, 4'h7, 64'ha5ffffffffffff3c};
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      waitIdle();
      if (!rows[i].rd)
        for (j = 0; j <= rows[i].len; j++)
          push(rows[i].d[8*j +: 8], ok);
      run(rows[i].rd, rows[i].addr, rows[i].len);
      check({7'h0, nack}, 8'h00);
      if (rows[i].rd)
      begin
        check(8'(nGot), {4'h0, rows[i].len} + 8'h01);
        for (j = 0; j <= rows[i].len; j++)
          check(got[j], rows[i].d[8*j +: 8]);
      end
      $display("test %0d end", i);
    end
    waitIdle();
    push(8'h5a, ok);
    run(1'b0, 8'h10, 4'h0);
    check({7'h0, busy}, 8'h01);
    push(8'h77, ok);
    run(1'b0, 8'h11, 4'h0);
    check({7'h0, nack}, 8'h01);
    check({7'h0, busy}, 8'h01);
    $display("test busy end");
    // the refused byte stays queued, so seven more fit
    n = 0;
    ok = 1'b1;
    while (ok === 1'b1 && n < 12)
    begin
      push(8'(n), ok);
      if (ok === 1'b1)
        n++;
    end
    check(8'(n), 8'h07);
    $display("test fill end");
    @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    check({6'h0, cmdReady, wrReady}, 8'h03);
    check({7'h0, busy}, 8'h00);
    check({6'h0, bus.scl, bus.sda}, {6'h0, LINES_RST});
    $display("test reset end");
    summarize();
  end
endmodule : serial_eeprom_two_wire_slave_test
